// ### hdl/wwdt_core.sv
// Windowed watchdog timing, status flags and reset output.
// Assumes the serial interface delivers decoded one-cycle register
// reads and writes, and the lock and enable bits come from elsewhere.
`timescale 1ns/1ps
module wwdt_core #(
  parameter int BASE_CYCLES = wwdt_pkg::WWDT_TICK_BASE_CYC,
  parameter int OPEN_SCALE = wwdt_pkg::WWDT_OPEN_SCALE
) (
  // Clock and reset
  input wire logic core_clk,
  input wire logic rst,
  // Register access
  input wire logic [7:0] reg_addr,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_wdata,
  output logic [7:0] reg_rdata_q,
  // Control bits held outside this block
  input wire logic timing_config_lock,
  input wire logic wd_enable,
  // Watchdog outputs
  output logic reset_output_pin_n_q,
  output logic simple_window_select_q
);

  // ****************************************************************
  // Checks and sizes
  // ****************************************************************
  localparam int WIN_W = 12;
  // Window counter width covers scales up to 247; the check stops at 64
  if (BASE_CYCLES < 1 || OPEN_SCALE < 1 || OPEN_SCALE > 64) begin : g_bad_params
    $error("wwdt_core: unsupported parameter values");
  end

  function automatic logic hit(input logic [7:0] a, input logic [7:0] ofs);
    return a == ofs;
  endfunction

  // ****************************************************************
  // Registers
  // ****************************************************************
  wwdt_pkg::wwdt_div_t div_q;
  wwdt_pkg::wwdt_win_t win_q;
  wwdt_pkg::wwdt_state_t state_q;
  logic early_refresh_flag_q;
  logic window_expired_flag_q;
  logic [31:0] base_cnt_q;
  logic [5:0] div_cnt_q;
  logic [WIN_W-1:0] win_cnt_q;
  logic base_tick;
  logic wd_tick;
  logic key_wr;
  logic stat_rd;
  logic [WIN_W-1:0] closed_len;
  logic [WIN_W-1:0] open_end;
  logic refresh_ok;
  logic early_set;
  logic expire_set;

  assign key_wr = reg_wr && hit(reg_addr, wwdt_pkg::WWDT_KEY_OFS) && wd_enable;
  assign stat_rd = reg_rd && hit(reg_addr, wwdt_pkg::WWDT_STATUS_OFS);

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      div_q <= wwdt_pkg::wwdt_div_t'(wwdt_pkg::WWDT_DIV_RST[6:0]);
      win_q <= wwdt_pkg::wwdt_win_t'(wwdt_pkg::WWDT_WIN_RST);
    end else if (reg_wr && !timing_config_lock) begin
      if (hit(reg_addr, wwdt_pkg::WWDT_DIV_OFS)) begin
        div_q <= wwdt_pkg::wwdt_div_t'(reg_wdata[6:0]);
      end
      if (hit(reg_addr, wwdt_pkg::WWDT_WIN_OFS)) begin
        win_q <= wwdt_pkg::wwdt_win_t'(reg_wdata);
      end
    end
  end

  // ****************************************************************
  // Tick generation
  // ****************************************************************
  // Base prescaler free runs so the tick phase never depends on refreshes
  assign base_tick = base_cnt_q == 32'(BASE_CYCLES - 1);
  assign wd_tick = base_tick && (div_cnt_q >= div_q.div);

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      base_cnt_q <= 32'h0000_0000;
    end else if (base_tick) begin
      base_cnt_q <= 32'h0000_0000;
    end else begin
      base_cnt_q <= base_cnt_q + 32'h0000_0001;
    end
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      div_cnt_q <= 6'h00;
    end else if (wd_tick) begin
      div_cnt_q <= 6'h00;
    end else if (base_tick) begin
      div_cnt_q <= div_cnt_q + 6'h01;
    end
  end

  // ****************************************************************
  // Window timer
  // ****************************************************************
  assign closed_len = WIN_W'((32'(win_q.opn) + 32'd1) * wwdt_pkg::WWDT_CLOSED_MULT);
  assign open_end = closed_len
    + WIN_W'((32'(win_q.clo) + 32'd1) * OPEN_SCALE);
  assign refresh_ok = state_q == wwdt_pkg::WWDT_ST_OPEN;
  assign early_set = key_wr && !refresh_ok;
  assign expire_set = wd_enable && refresh_ok && wd_tick && !key_wr
    && (win_cnt_q + WIN_W'(1) >= open_end);

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      state_q <= wwdt_pkg::WWDT_ST_CLOSED;
      win_cnt_q <= '0;
    end else if (!wd_enable || key_wr || expire_set) begin
      // Any refresh, violation or expiry starts a fresh closed window
      state_q <= wwdt_pkg::WWDT_ST_CLOSED;
      win_cnt_q <= '0;
    end else if (wd_tick) begin
      win_cnt_q <= win_cnt_q + WIN_W'(1);
      unique case (state_q)
        wwdt_pkg::WWDT_ST_CLOSED: begin
          if (win_cnt_q + WIN_W'(1) >= closed_len) begin
            state_q <= wwdt_pkg::WWDT_ST_OPEN;
          end
        end
        wwdt_pkg::WWDT_ST_OPEN: begin
          state_q <= wwdt_pkg::WWDT_ST_OPEN;
        end
        default: begin
          state_q <= wwdt_pkg::WWDT_ST_CLOSED;
        end
      endcase
    end
  end

  // ****************************************************************
  // Status flags
  // ****************************************************************
  // Set beats the clearing read so no event is lost
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      early_refresh_flag_q <= 1'b0;
      window_expired_flag_q <= 1'b0;
    end else begin
      early_refresh_flag_q <= early_set || (early_refresh_flag_q && !stat_rd);
      window_expired_flag_q <= expire_set || (window_expired_flag_q && !stat_rd);
    end
  end

  // ****************************************************************
  // Outputs
  // ****************************************************************
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      reset_output_pin_n_q <= 1'b1;
    end else begin
      reset_output_pin_n_q <= !(wd_enable
        && (early_refresh_flag_q || window_expired_flag_q));
    end
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      simple_window_select_q <= 1'b0;
    end else begin
      simple_window_select_q <= div_q.sww;
    end
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      reg_rdata_q <= 8'h00;
    end else if (reg_rd) begin
      reg_rdata_q <= 8'h00;
      if (hit(reg_addr, wwdt_pkg::WWDT_STATUS_OFS)) begin
        reg_rdata_q[wwdt_pkg::WWDT_OPEN_BIT] <= refresh_ok && wd_enable;
        reg_rdata_q[wwdt_pkg::WWDT_EARLY_BIT] <= early_refresh_flag_q;
        reg_rdata_q[wwdt_pkg::WWDT_EXP_BIT] <= window_expired_flag_q;
      end else if (hit(reg_addr, wwdt_pkg::WWDT_DIV_OFS)) begin
        reg_rdata_q <= {1'b0, div_q};
      end else if (hit(reg_addr, wwdt_pkg::WWDT_WIN_OFS)) begin
        reg_rdata_q <= win_q;
      end
    end
  end

endmodule // wwdt_core

// ### hdl/wwdt_pkg.sv
// Constants and types of the windowed watchdog timing block.
// Assumes one 250 MHz core clock and a decoded register access port.
// Operation
// - A key write before the closed window has elapsed sets the early refresh flag, status bit 1.
// - A window that ends with no key write sets the window expired flag, status bit 0.
// - Both flags stay latched until the status register is read, and that read clears them.
// - While the watchdog is enabled, either flag drives the reset output low, with no mask.
// - Status bit 3 shows live whether the open window is active and a key write is allowed.
// - Divider bit 6 picks challenge/response when 0 and simple windowed operation when 1.
// - The tick period is the divider field in bits 5:0 plus one, times 121.905 us.
// - The closed window lasts the tick period times the field in bits 7:4 plus one, times 8.
// - The open window ends after a further tick period times bits 3:0 plus one, times a scale.
// - Divider and window length registers take writes only while the lock bit is 0.
package wwdt_pkg;

  // ****************************************************************
  // Register map
  // ****************************************************************
  localparam logic [7:0] WWDT_STATUS_OFS = 8'h0D;
  localparam logic [7:0] WWDT_DIV_OFS = 8'h12;
  localparam logic [7:0] WWDT_WIN_OFS = 8'h13;
  localparam logic [7:0] WWDT_KEY_OFS = 8'h15;

  // ****************************************************************
  // Field positions
  // ****************************************************************
  localparam int WWDT_EXP_BIT = 0;
  localparam int WWDT_EARLY_BIT = 1;
  localparam int WWDT_OPEN_BIT = 3;
  localparam int WWDT_SWW_BIT = 6;
  localparam int WWDT_DIV_LSB = 0;
  localparam int WWDT_CLO_LSB = 0;
  localparam int WWDT_OPN_LSB = 4;

  // ****************************************************************
  // Reset values (stand-ins for factory loaded defaults)
  // ****************************************************************
  localparam logic [7:0] WWDT_DIV_RST = 8'h40;
  localparam logic [7:0] WWDT_WIN_RST = 8'h00;

  // ****************************************************************
  // Timing
  // ****************************************************************
  localparam longint WWDT_CLK_PS = 4000;
  localparam longint WWDT_TICK_BASE_PS = 121905000;
  localparam int WWDT_TICK_BASE_CYC = int'(WWDT_TICK_BASE_PS / WWDT_CLK_PS);
  localparam int WWDT_CLOSED_MULT = 8;
  localparam int WWDT_OPEN_SCALE = 8;

  // ****************************************************************
  // Types
  // ****************************************************************
  typedef enum logic [1:0] {
    WWDT_ST_CLOSED = 2'b01,
    WWDT_ST_OPEN = 2'b10
  } wwdt_state_t;

  typedef struct packed {
    logic sww;
    logic [5:0] div;
  } wwdt_div_t;

  typedef struct packed {
    logic [3:0] opn;
    logic [3:0] clo;
  } wwdt_win_t;

endpackage

// ### verification/tb.sv
// Bench for wwdt_core; a tick is 4 clocks, open scale 8.
`timescale 1ns/1ps
module tb;
  logic core_clk = 1'b0;
  logic rst = 1'b1;
  logic timing_config_lock = 1'b0;
  logic wd_enable = 1'b0;
  logic reg_wr, reg_rd, reset_output_pin_n_q, simple_window_select_q;
  logic [7:0] reg_addr, reg_wdata, reg_rdata_q, v;
  int mismatches = 0, num_checks = 0, div_m = 8'h40, win_m = 0;
  wwdt_core #(.BASE_CYCLES(4)) dut (.*);
  wwdt_host host (.*);
  initial forever #2 core_clk = ~core_clk;
  initial begin
    repeat (3000) @(posedge core_clk);
    mismatches++;
    tally_and_finish();
  end
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", num_checks, mismatches);
    if (mismatches == 0 && num_checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  task automatic chk(input string what, input logic [7:0] e, input logic [7:0] g);
    num_checks++;
    if (g !== e) begin
      mismatches++;
      $display("BAD %s exp %h got %h", what, e, g);
    end
  endtask
  task automatic ctl(input logic l, input logic e);
    @(posedge core_clk);
    timing_config_lock <= l;
    wd_enable <= e;
  endtask
  task automatic wreg(input logic [7:0] a, input logic [7:0] d);
    host.put(a, d);
    if (!timing_config_lock && a == 8'h12) div_m = d & 8'h7F;
    if (!timing_config_lock && a == 8'h13) win_m = d;
  endtask
  task automatic rreg(input logic [7:0] a, input logic [7:0] e, input string what);
    host.get(a, v);
    chk(what, e, v);
  endtask
  initial begin
    v = 8'($urandom(32'h8E638E15));
    repeat (10) @(posedge core_clk);
    rst <= 1'b0;
    rreg(8'h12, 8'h40, "div reset");
    rreg(8'h13, 8'h00, "win reset");
    chk("sww reset", 8'h01, {7'h0, simple_window_select_q});
    ctl(1'b1, 1'b0);
    wreg(8'h12, 8'h00);
    rreg(8'h12, 8'(div_m), "div locked");
    ctl(1'b0, 1'b0);
    wreg(8'h13, 8'($urandom));
    rreg(8'h13, 8'(win_m), "win rw");
    wreg(8'h12, 8'($urandom) | 8'h80);
    rreg(8'h12, 8'(div_m), "div rw");
    wreg(8'h12, 8'h00);
    wreg(8'h13, 8'h00);
    chk("sww cleared", 8'h00, {7'h0, simple_window_select_q});
    rreg(8'h20, 8'h00, "unmapped");
    $display("test config done");
    ctl(1'b0, 1'b1);
    wreg(8'h15, 8'h5A);
    rreg(8'h0D, 8'h02, "early flag");
    chk("pin early", 8'h00, {7'h0, reset_output_pin_n_q});
    rreg(8'h0D, 8'h00, "flag cleared");
    chk("pin freed", 8'h01, {7'h0, reset_output_pin_n_q});
    $display("test early done");
    for (int i = 0; i < 60 && v[3] !== 1'b1; i++) host.get(8'h0D, v);
    chk("open bit", 8'h08, v);
    wreg(8'h15, 8'hA5);
    rreg(8'h0D, 8'h00, "closed again");
    $display("test open done");
    // Full closed plus open span, plus slack for the free running tick
    repeat (((win_m >> 4) + (win_m & 15) + 2) * 8 * (div_m % 64 + 1) * 4 + 8)
      @(posedge core_clk);
    chk("pin expired", 8'h00, {7'h0, reset_output_pin_n_q});
    rreg(8'h0D, 8'h01, "expired flag");
    ctl(1'b0, 1'b0);
    repeat (80) @(posedge core_clk);
    chk("pin disabled", 8'h01, {7'h0, reset_output_pin_n_q});
    $display("test expiry done");
    tally_and_finish();
  end
endmodule // tb

// ### verification/wwdt_checker.sv
// Port assertions for wwdt_core; bound to it, one clock domain.
`timescale 1ns/1ps
module wwdt_checker #(
  parameter int BASE_CYCLES = 4,
  parameter int OPEN_SCALE = 8
) (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic [7:0] reg_addr,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_wdata,
  input wire logic [7:0] reg_rdata_q,
  input wire logic timing_config_lock,
  input wire logic wd_enable,
  input wire logic reset_output_pin_n_q,
  input wire logic simple_window_select_q
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (rst);
  logic [15:0] idle_q;
  wire key_wr = reg_wr && reg_addr == 8'h15 && wd_enable;
  wire st_rd = reg_rd && reg_addr == 8'h0D;
  wire dv_wr = reg_wr && reg_addr == 8'h12;
  // One tick of margin, the tick phase survives a refresh
  wire closed = idle_q < 16'(6 * BASE_CYCLES);
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) idle_q <= 16'h0;
    else if (!wd_enable || key_wr) idle_q <= 16'h0;
    else if (idle_q != 16'hFFFF) idle_q <= idle_q + 16'h1;
  end
  a_sww_follow: assert property (dv_wr && !timing_config_lock ##1 !reg_wr
    |=> simple_window_select_q == $past(reg_wdata[6], 2)) else $error("sww stale");
  a_lock_hold: assert property (dv_wr && timing_config_lock ##1 !reg_wr
    |=> $stable(simple_window_select_q)) else $error("locked write taken");
  a_disable_high: assert property (!wd_enable
    |=> reset_output_pin_n_q) else $error("reset low while disabled");
  a_fall_enabled: assert property ($fell(reset_output_pin_n_q)
    |-> $past(wd_enable)) else $error("reset fell while disabled");
  a_flag_latched: assert property (!reset_output_pin_n_q && wd_enable
    && !st_rd && !$past(st_rd) |=> !reset_output_pin_n_q) else $error("flag lost");
  a_early_rst: assert property (key_wr && closed ##1 wd_enable ##1 wd_enable
    |-> ##[0:1] !reset_output_pin_n_q) else $error("early refresh unseen");
  a_early_status: assert property (key_wr && closed ##1 !st_rd ##1 st_rd
    |=> reg_rdata_q[1]) else $error("early bit missing");
  a_closed_bit: assert property (st_rd && closed
    |=> !reg_rdata_q[3]) else $error("open bit in closed window");
endmodule // wwdt_checker
bind wwdt_core wwdt_checker #(.BASE_CYCLES(BASE_CYCLES), .OPEN_SCALE(OPEN_SCALE)) u_chk (.*);

// ### verification/wwdt_host.sv
// Host model: one-cycle register writes and reads.
`timescale 1ns/1ps
module wwdt_host (
  input wire logic core_clk,
  input wire logic [7:0] reg_rdata_q,
  output logic [7:0] reg_addr,
  output logic reg_wr,
  output logic reg_rd,
  output logic [7:0] reg_wdata
);
  initial begin
    reg_addr = 8'h00;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_wdata = 8'h00;
  end
  task automatic put(input logic [7:0] a, input logic [7:0] d);
    @(posedge core_clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge core_clk);
    reg_wr <= 1'b0;
  endtask
  task automatic get(input logic [7:0] a, output logic [7:0] d);
    @(posedge core_clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge core_clk);
    reg_rd <= 1'b0;
    @(negedge core_clk);
    d = reg_rdata_q;
  endtask
endmodule // wwdt_host
